// ### hw/ccsu_defines.svh
// offsets, field positions, reset values and characters of the common command unit
`ifndef CCSU_DEFINES_SVH
`define CCSU_DEFINES_SVH
// register byte offsets
`define A_CMD   8'h00
`define A_QRY   8'h04
`define A_ARG   8'h08
`define A_RESP  8'h0C
`define A_STB   8'h10
`define A_IST   8'h14
`define A_IMSK  8'h18
`define A_GRP   2'b01
// status byte, event register and interrupt bit positions
`define SB_QUES 3
`define SB_MAV  4
`define SB_ESB  5
`define SB_MSS  6
`define SB_OPER 7
`define ES_OPC  0
`define ES_CME  5
`define IS_SRQ  0
`define IS_RSP  1
`define IS_CME  2
`define IS_OPC  3
// reset values
`define RV_PSC  1'b1
`define RV_REG  8'h00
// characters and command letters
`define CH_STAR  8'h2A
`define CH_LF    8'h0A
`define CH_ZERO  8'h30
`define CH_COMMA 8'h2C
`define CH_OPTA  8'h41
`define CH_OPTB  8'h42
`define L_CAL 24'h43_414C
`define L_CLS 24'h43_4C53
`define L_ESE 24'h45_5345
`define L_ESR 24'h45_5352
`define L_IDN 24'h49_444E
`define L_OPC 24'h4F_5043
`define L_OPT 24'h4F_5054
`define L_PSC 24'h50_5343
`define L_RST 24'h52_5354
`define L_SRE 24'h53_5245
`define L_STB 24'h53_5442
`define L_TRG 24'h54_5247
`define L_WAI 24'h57_4149
// identity text, arbitrary value
`define IDN_LEN   20
`define IDN_TEXT  "NONAME,CCSU,0001,1.0"
`define BUF_DEPTH 24
`endif

// ### hw/ccsu_pkg.sv
// types shared by the common command and status unit
package ccsu_pkg;
    typedef enum logic [4:0] {c_cls, c_ese, c_ese_q, c_esr_q, c_idn_q, c_opc, c_opc_q,
        c_opt_q, c_psc, c_psc_q, c_rst, c_sre, c_sre_q, c_stb_q, c_trg, c_wai, c_cal_q,
        c_bad} cmd_t;
    typedef enum logic {ex_idle, ex_cal} exec_t;
    typedef enum logic [1:0] {rk_num, rk_idn, rk_opt} resp_kind_t;
    typedef struct packed {
        logic       valid;
        cmd_t       code;
        logic [7:0] arg;
    } slot_t;
    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] ntr;
        logic [7:0] en;
        logic [7:0] evt;
    } grp_t;
endpackage : ccsu_pkg

// ### hw/ccsu_top.sv
// common command interpreter with status reporting behind an ahb-lite slave
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ccsu_defines.svh"
module ccsu_top
    import ccsu_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        busy,
    input  wire logic        cal_done,
    input  wire logic [7:0]  cal_status,
    input  wire logic [7:0]  ques_cond,
    input  wire logic [7:0]  oper_cond,
    input  wire logic [1:0]  opt_installed,
    input  wire logic        power_on,
    output logic             trigger_pulse,
    output logic             settings_reset,
    output logic             cal_start,
    output logic             irq
);
    localparam logic [8*`IDN_LEN-1:0] IDN = `IDN_TEXT;

    slot_t       slot;
    exec_t       state;
    resp_kind_t  load_kind;
    grp_t        grp [2];
    logic [7:0]  cond [2];
    logic [7:0]  prev [2];
    logic [7:0]  rbuf [`BUF_DEPTH];
    logic [1:0]  gsum;
    logic [4:0]  rlen;
    logic [4:0]  rptr;
    logic [7:0]  dp_addr;
    logic [7:0]  arg;
    logic [7:0]  ese;
    logic [7:0]  sre;
    logic [7:0]  esr;
    logic [7:0]  esr_set;
    logic [7:0]  stb;
    logic [7:0]  next_stb;
    logic [7:0]  ist;
    logic [7:0]  ist_set;
    logic [7:0]  imsk;
    logic [7:0]  load_val;
    logic [31:0] rdata;
    logic        dp_act;
    logic        dp_wr;
    logic        stall;
    logic        wr_now;
    logic        rd_now;
    logic        take_cmd;
    logic        quiet;
    logic        exec_now;
    logic        cal_go;
    logic        slot_done;
    logic        do_cls;
    logic        do_opc;
    logic        do_bad;
    logic        load;
    logic        psc;
    logic        mav;
    logic        mss_q;

    // header check: star then three known letters, query form where allowed
    function automatic cmd_t decode(input logic [31:0] h, input logic q);
        cmd_t c;
        c = c_bad;
        if (h[31:24] == `CH_STAR)
        begin
            case (h[23:0])
                `L_CAL:  c = q ? c_cal_q : c_bad;
                `L_CLS:  c = q ? c_bad : c_cls;
                `L_ESE:  c = q ? c_ese_q : c_ese;
                `L_ESR:  c = q ? c_esr_q : c_bad;
                `L_IDN:  c = q ? c_idn_q : c_bad;
                `L_OPC:  c = q ? c_opc_q : c_opc;
                `L_OPT:  c = q ? c_opt_q : c_bad;
                `L_PSC:  c = q ? c_psc_q : c_psc;
                `L_RST:  c = q ? c_bad : c_rst;
                `L_SRE:  c = q ? c_sre_q : c_sre;
                `L_STB:  c = q ? c_stb_q : c_bad;
                `L_TRG:  c = q ? c_bad : c_trg;
                `L_WAI:  c = q ? c_bad : c_wai;
                default: c = c_bad;
            endcase
        end
        return c;
    endfunction : decode

    function automatic logic [7:0] dig(input logic [7:0] d);
        return `CH_ZERO + d;
    endfunction : dig

    // data phase; a command write waits while the slot still holds one
    assign stall    = dp_act && dp_wr && slot.valid && (dp_addr == `A_CMD || dp_addr == `A_QRY);
    assign wr_now   = dp_act && !hreadyout && dp_wr && !stall;
    assign rd_now   = dp_act && !hreadyout && !dp_wr;
    assign take_cmd = wr_now && (dp_addr == `A_CMD || dp_addr == `A_QRY);

    // address phase capture, one wait state per transfer unless a command write stalls
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            dp_act    <= 1'b0;
            dp_wr     <= 1'b0;
            dp_addr   <= 8'h00;
        end
        else if (hreadyout)
        begin
            dp_act    <= hsel && hready && htrans[1];
            dp_wr     <= hwrite;
            dp_addr   <= haddr[7:0];
            hreadyout <= !(hsel && hready && htrans[1]);
        end
        else if (!stall)
        begin
            hreadyout <= 1'b1;
        end
    end

    // read mux; unmapped words read zero
    always_comb
    begin
        rdata = 32'h0000_0000;
        if (dp_addr[7:6] == `A_GRP && !dp_addr[5])
        begin
            case (dp_addr[3:2])
                2'd0:    rdata[7:0] = grp[dp_addr[4]].ptr;
                2'd1:    rdata[7:0] = grp[dp_addr[4]].ntr;
                2'd2:    rdata[7:0] = grp[dp_addr[4]].en;
                default: rdata[7:0] = grp[dp_addr[4]].evt;
            endcase
        end
        else
        begin
            case (dp_addr)
                `A_CMD,
                `A_QRY:  rdata[0] = slot.valid;
                `A_ARG:  rdata[7:0] = arg;
                `A_RESP: rdata[8:0] = {mav, rbuf[rptr]};
                `A_STB:  rdata[7:0] = stb;
                `A_IST:  rdata[7:0] = ist;
                `A_IMSK: rdata[7:0] = imsk;
                default: rdata = 32'h0000_0000;
            endcase
        end
    end

    // read data and response; errors never signalled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hresp  <= 1'b0;
        end
        else
        begin
            hresp <= 1'b0;
            if (rd_now)
                hrdata <= rdata;
        end
    end

    // argument register, sampled into the slot with the header
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            arg <= `RV_REG;
        else if (wr_now && dp_addr == `A_ARG)
            arg <= hwdata[7:0];
    end

    // single command slot, freed when the command has run
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            slot <= '0;
        else if (take_cmd)
            slot <= '{valid: 1'b1, code: decode(hwdata, dp_addr == `A_QRY), arg: arg};
        else if (slot_done)
            slot.valid <= 1'b0;
    end

    // completion-bound commands wait for the device to go idle
    assign quiet     = slot.code == c_opc || slot.code == c_opc_q || slot.code == c_wai;
    assign exec_now  = slot.valid && state == ex_idle && slot.code != c_cal_q
                       && !(quiet && busy);
    assign cal_go    = slot.valid && state == ex_idle && slot.code == c_cal_q;
    assign slot_done = exec_now || (state == ex_cal && cal_done);
    assign do_cls    = exec_now && slot.code == c_cls;
    assign do_opc    = exec_now && slot.code == c_opc;
    assign do_bad    = exec_now && slot.code == c_bad;

    // alignment runs outside; the slot blocks later commands meanwhile
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state <= ex_idle;
        else
        begin
            unique case (state)
                ex_idle: if (cal_go) state <= ex_cal;
                ex_cal:  if (cal_done) state <= ex_idle;
            endcase
        end
    end

    // choose what a query puts into the output buffer
    always_comb
    begin
        load      = 1'b0;
        load_kind = rk_num;
        load_val  = 8'h00;
        if (state == ex_cal && cal_done)
        begin
            load     = 1'b1;
            load_val = cal_status;
        end
        else if (exec_now)
        begin
            load = 1'b1;
            case (slot.code)
                c_ese_q: load_val = ese;
                c_esr_q: load_val = esr;
                c_sre_q: load_val = sre;
                c_stb_q: load_val = stb;
                c_psc_q: load_val = {7'b000_0000, psc};
                c_opc_q: load_val = 8'h01;
                c_idn_q: load_kind = rk_idn;
                c_opt_q: load_kind = rk_opt;
                default: load = 1'b0;
            endcase
        end
    end

    // output buffer; a new answer replaces any unread one
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rlen <= 5'd0;
            rptr <= 5'd0;
            for (int i = 0; i < `BUF_DEPTH; i++)
                rbuf[i] <= 8'h00;
        end
        else if (do_cls)
        begin
            rlen <= 5'd0;
            rptr <= 5'd0;
        end
        else if (load)
        begin
            rptr <= 5'd0;
            unique case (load_kind)
                rk_num:
                begin
                    if (load_val >= 8'd100)
                    begin
                        rbuf[0] <= dig(load_val / 8'd100);
                        rbuf[1] <= dig((load_val / 8'd10) % 8'd10);
                        rbuf[2] <= dig(load_val % 8'd10);
                        rbuf[3] <= `CH_LF;
                        rlen    <= 5'd4;
                    end
                    else if (load_val >= 8'd10)
                    begin
                        rbuf[0] <= dig(load_val / 8'd10);
                        rbuf[1] <= dig(load_val % 8'd10);
                        rbuf[2] <= `CH_LF;
                        rlen    <= 5'd3;
                    end
                    else
                    begin
                        rbuf[0] <= dig(load_val);
                        rbuf[1] <= `CH_LF;
                        rlen    <= 5'd2;
                    end
                end
                rk_idn:
                begin
                    for (int i = 0; i < `IDN_LEN; i++)
                        rbuf[i] <= IDN[8*(`IDN_LEN-1-i) +: 8];
                    rbuf[`IDN_LEN] <= `CH_LF;
                    rlen           <= 5'(`IDN_LEN + 1);
                end
                rk_opt:
                begin
                    rbuf[0] <= opt_installed[0] ? `CH_OPTA : `CH_ZERO;
                    rbuf[1] <= `CH_COMMA;
                    rbuf[2] <= opt_installed[1] ? `CH_OPTB : `CH_ZERO;
                    rbuf[3] <= `CH_LF;
                    rlen    <= 5'd4;
                end
            endcase
        end
        else if (rd_now && dp_addr == `A_RESP && mav)
            rptr <= rptr + 5'd1;
    end

    assign mav = rptr < rlen;

    // event status register; a set in the clearing cycle survives
    always_comb
    begin
        esr_set          = 8'h00;
        esr_set[`ES_OPC] = do_opc;
        esr_set[`ES_CME] = do_bad;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            esr <= `RV_REG;
        else if (do_cls || (exec_now && slot.code == c_esr_q))
            esr <= esr_set;
        else
            esr <= esr | esr_set;
    end

    // enable registers and the power-on clear flag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ese <= `RV_REG;
            sre <= `RV_REG;
            psc <= `RV_PSC;
        end
        else if (power_on && psc)
        begin
            ese <= `RV_REG;
            sre <= `RV_REG;
        end
        else if (exec_now)
        begin
            case (slot.code)
                c_ese:   ese <= slot.arg;
                c_sre:
                begin
                    sre          <= slot.arg;
                    sre[`SB_MSS] <= 1'b0;
                end
                c_psc:   psc <= |slot.arg;
                default: ;
            endcase
        end
    end

    // questionable and operation groups; clear touches only events
    assign cond[0] = ques_cond;
    assign cond[1] = oper_cond;
    for (genvar g = 0; g < 2; g++)
    begin : g_grp
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                grp[g]  <= '0;
                prev[g] <= 8'h00;
            end
            else
            begin
                prev[g]    <= cond[g];
                grp[g].evt <= (do_cls ? 8'h00 : grp[g].evt)
                              | (cond[g] & ~prev[g] & grp[g].ptr)
                              | (~cond[g] & prev[g] & grp[g].ntr);
                if (wr_now && dp_addr[7:6] == `A_GRP && !dp_addr[5] && dp_addr[4] == 1'(g))
                begin
                    case (dp_addr[3:2])
                        2'd0:    grp[g].ptr <= hwdata[7:0];
                        2'd1:    grp[g].ntr <= hwdata[7:0];
                        2'd2:    grp[g].en  <= hwdata[7:0];
                        default: ;
                    endcase
                end
                if (power_on && psc)
                    grp[g].en <= 8'h00;
            end
        end
        assign gsum[g] = |(grp[g].evt & grp[g].en);
    end

    // status byte summary; read only through its query or register
    always_comb
    begin
        next_stb           = 8'h00;
        next_stb[`SB_QUES] = gsum[0];
        next_stb[`SB_MAV]  = mav;
        next_stb[`SB_ESB]  = |(esr & ese);
        next_stb[`SB_OPER] = gsum[1];
        next_stb[`SB_MSS]  = |(next_stb & sre);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stb <= `RV_REG;
        else
            stb <= next_stb;
    end

    // interrupt events: service request edge, answer, bad header, complete
    always_comb
    begin
        ist_set          = 8'h00;
        ist_set[`IS_SRQ] = stb[`SB_MSS] && !mss_q;
        ist_set[`IS_RSP] = load;
        ist_set[`IS_CME] = do_bad;
        ist_set[`IS_OPC] = do_opc;
    end

    // write one to clear; a new event in that cycle wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ist   <= `RV_REG;
            imsk  <= `RV_REG;
            mss_q <= 1'b0;
            irq   <= 1'b0;
        end
        else
        begin
            mss_q <= stb[`SB_MSS];
            irq   <= |(ist & imsk);
            if (wr_now && dp_addr == `A_IST)
                ist <= (ist & ~hwdata[7:0]) | ist_set;
            else
                ist <= ist | ist_set;
            if (wr_now && dp_addr == `A_IMSK)
                imsk <= hwdata[7:0];
        end
    end

    // one-cycle strobes to the acquisition side
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trigger_pulse  <= 1'b0;
            settings_reset <= 1'b0;
            cal_start      <= 1'b0;
        end
        else
        begin
            trigger_pulse  <= exec_now && slot.code == c_trg;
            settings_reset <= exec_now && slot.code == c_rst;
            cal_start      <= cal_go;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_cls_zeroes: assert property (do_cls |=> esr == 8'h00 && !mav)
        else $error("clear status left events or output");
    a_cls_masks_kept: assert property (do_cls && !power_on
        |=> $stable(ese) && $stable(sre) && $stable(grp[0].ptr) && $stable(grp[1].en))
        else $error("clear status changed a mask");
    a_cls_drops_output: assert property (mav && do_cls |=> rlen == 5'd0)
        else $error("clear status kept output");
    a_ese_load_value: assert property (exec_now && slot.code == c_ese && !power_on
        |=> ese == $past(slot.arg))
        else $error("enable register not loaded");
    a_esr_read_clear: assert property (exec_now && slot.code == c_esr_q |=> esr == 8'h00)
        else $error("event register not cleared by read");
    a_opc_sets_bit: assert property (do_opc |-> !busy ##1 esr[`ES_OPC])
        else $error("complete bit wrong");
    a_srq_from_opc: assert property (do_opc && ese[`ES_OPC] && sre[`SB_ESB] && !power_on
        |=> ##1 stb[`SB_MSS])
        else $error("complete did not reach request");
    a_opcq_answer: assert property (exec_now && slot.code == c_opc_q
        |=> rlen == 5'd2 && rbuf[0] == 8'h31 && !$past(busy))
        else $error("complete query answer wrong");
    a_psc_clears: assert property (power_on && psc |=> ese == 8'h00 && sre == 8'h00)
        else $error("power-on clear ignored");
    a_sre_mss_zero: assert property (exec_now && slot.code == c_sre && !power_on
        |=> !sre[`SB_MSS] && sre[5:0] == $past(slot.arg[5:0]))
        else $error("request enable load wrong");
    a_trg_one_pulse: assert property (exec_now && slot.code == c_trg
        |=> trigger_pulse ##1 !trigger_pulse)
        else $error("trigger pulse wrong");
    a_wai_holds_off: assert property (slot.valid && slot.code == c_wai && busy |-> !slot_done)
        else $error("wait released while busy");
    a_header_check: assert property (take_cmd && hwdata[31:24] != `CH_STAR
        |=> slot.code == c_bad)
        else $error("bad header accepted");
    a_digit_format: assert property (load && load_kind == rk_num && load_val < 8'd10
        |=> rlen == 5'd2 && rbuf[1] == `CH_LF && rbuf[0] == `CH_ZERO + $past(load_val))
        else $error("single digit answer wrong");
endmodule : ccsu_top

// ### verif/core_model.sv
// instrument core stand-in: busy after trigger or reset, late alignment result
`timescale 1ns/10ps
module core_model
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       trigger_pulse,
    input  wire logic       settings_reset,
    input  wire logic       cal_start,
    input  wire logic [7:0] cal_code,
    output logic            busy,
    output logic            cal_done,
    output logic [7:0]      cal_status
);
    int busy_left;
    int cal_left;
    // busy runs long enough that waiting commands are seen to wait
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) busy_left <= 0;
        else if (trigger_pulse || settings_reset) busy_left <= 40;
        else if (busy_left > 0) busy_left <= busy_left - 1;
    assign busy = busy_left > 0;
    // alignment answers late; result only holds during the done pulse
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn) cal_left <= 0;
        else if (cal_start) cal_left <= 30;
        else if (cal_left > 0) cal_left <= cal_left - 1;
    assign cal_done   = cal_left == 1;
    assign cal_status = cal_done ? cal_code : ~cal_code;
endmodule : core_model

// ### verif/common_command_status_unit_tb.sv
// self-checking bench for the common command and status unit
`timescale 1ns/10ps
`include "ccsu_defines.svh"
`define chk(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch at %0t: got %0h", $time, (g)); end end
module common_command_status_unit_tb;
    logic        hclk = 0, hresetn = 0, hwrite = 0, power_on = 0;
    logic [1:0]  htrans = 0, opt = 2'b10;
    logic [7:0]  ques = 0, oper = 0, cal_status;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic        hreadyout, hresp, busy, cal_done, trigger_pulse, settings_reset;
    logic        cal_start, irq;
    int          fail_count = 0, total_checks = 0, n_trg = 0, n_rst = 0, n_cal = 0;

    ccsu_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .busy(busy), .cal_done(cal_done), .cal_status(cal_status), .ques_cond(ques),
        .oper_cond(oper), .opt_installed(opt), .power_on(power_on),
        .trigger_pulse(trigger_pulse), .settings_reset(settings_reset),
        .cal_start(cal_start), .irq(irq));
    core_model core (.hclk(hclk), .hresetn(hresetn), .trigger_pulse(trigger_pulse),
        .settings_reset(settings_reset), .cal_start(cal_start), .cal_code(8'h03),
        .busy(busy), .cal_done(cal_done), .cal_status(cal_status));

    always #5 hclk = ~hclk;
    // one-cycle pulses are counted so no edge is missed
    always @(posedge hclk)
    begin
        n_trg += trigger_pulse;
        n_rst += settings_reset;
        n_cal += cal_start;
    end

    // single word transfer; waits on ready, no fixed latency assumed
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        haddr  <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        `chk(hresp, 1'b0)
    endtask : xfer

    task automatic cmd(input logic [23:0] l, input logic [7:0] v);
        logic [31:0] q;
        xfer(1'b1, `A_ARG, {24'h0, v}, q);
        xfer(1'b1, `A_CMD, {`CH_STAR, l}, q);
    endtask : cmd

    // query, then drain the answer one character per read
    task automatic ask(input logic [23:0] l, input string e);
        logic [31:0] q;
        string       s;
        int          n;
        s = "";
        n = 0;
        xfer(1'b1, `A_QRY, {`CH_STAR, l}, q);
        do xfer(1'b0, `A_RESP, 32'h0, q); while (q[8] !== 1'b1 && ++n < 300);
        while (q[8] === 1'b1)
        begin
            s = $sformatf("%s%c", s, q[7:0]);
            xfer(1'b0, `A_RESP, 32'h0, q);
        end
        `chk(s == e, 1'b1)
    endtask : ask

    task automatic pwr;
        power_on <= 1'b1;
        @(posedge hclk);
        power_on <= 1'b0;
        @(posedge hclk);
    endtask : pwr

    task automatic t_reset;
        logic [31:0] q;
        xfer(1'b0, `A_STB, 32'h0, q);
        `chk(q, 32'h0)
        xfer(1'b0, 8'h30, 32'h0, q);
        `chk(q, 32'h0)
        ask(`L_PSC, "1\n");
        $display("done reset");
    endtask : t_reset

    task automatic t_enables;
        cmd(`L_ESE, 8'hFF);
        ask(`L_ESE, "255\n");
        cmd(`L_SRE, 8'hFF);
        ask(`L_SRE, "191\n");
        ask(`L_STB, "0\n");
        $display("done enables");
    endtask : t_enables

    task automatic t_errors;
        logic [31:0] q;
        xfer(1'b1, `A_CMD, 32'h2A58_595A, q);
        xfer(1'b1, `A_QRY, {`CH_STAR, `L_CLS}, q);
        ask(`L_ESR, "32\n");
        ask(`L_ESR, "0\n");
        $display("done errors");
    endtask : t_errors

    task automatic t_opc;
        logic [31:0] q;
        cmd(`L_TRG, 8'h00);
        cmd(`L_OPC, 8'h00);
        xfer(1'b0, `A_STB, 32'h0, q);
        `chk(q[5], 1'b0)
        ask(`L_OPC, "1\n");
        `chk(busy, 1'b0)
        `chk(n_trg, 1)
        ask(`L_STB, "96\n");
        ask(`L_STB, "96\n");
        `chk(irq, 1'b0)
        xfer(1'b1, `A_IMSK, 32'h8, q);
        @(posedge hclk);
        `chk(irq, 1'b1)
        xfer(1'b1, `A_IST, 32'h8, q);
        @(posedge hclk);
        `chk(irq, 1'b0)
        ask(`L_ESR, "1\n");
        $display("done opc");
    endtask : t_opc

    task automatic t_misc;
        cmd(`L_RST, 8'h00);
        cmd(`L_WAI, 8'h00);
        cmd(`L_ESE, 8'h07);
        `chk(busy, 1'b0)
        `chk(n_rst, 1)
        ask(`L_ESE, "7\n");
        ask(`L_CAL, "3\n");
        `chk(n_cal, 1)
        ask(`L_IDN, {`IDN_TEXT, "\n"});
        ask(`L_OPT, "0,B\n");
        opt <= 2'b01;
        ask(`L_OPT, "A,0\n");
        $display("done misc");
    endtask : t_misc

    task automatic t_cls;
        logic [31:0] q;
        xfer(1'b1, 8'h40, 32'hFF, q);
        xfer(1'b1, 8'h50, 32'hFF, q);
        ques <= 8'h01;
        oper <= 8'h01;
        xfer(1'b1, `A_QRY, {`CH_STAR, `L_ESE}, q);
        xfer(1'b1, `A_CMD, 32'h2A58_595A, q);
        xfer(1'b0, 8'h4C, 32'h0, q);
        `chk(q[0], 1'b1)
        xfer(1'b0, 8'h5C, 32'h0, q);
        `chk(q, 32'h1)
        cmd(`L_CLS, 8'h00);
        @(posedge hclk);
        xfer(1'b0, `A_RESP, 32'h0, q);
        `chk(q[8], 1'b0)
        xfer(1'b0, 8'h4C, 32'h0, q);
        `chk(q, 32'h0)
        xfer(1'b0, 8'h5C, 32'h0, q);
        `chk(q, 32'h0)
        xfer(1'b0, 8'h40, 32'h0, q);
        `chk(q, 32'hFF)
        ask(`L_STB, "0\n");
        ask(`L_ESR, "0\n");
        ask(`L_ESE, "7\n");
        $display("done clear");
    endtask : t_cls

    task automatic t_psc;
        cmd(`L_PSC, 8'h00);
        pwr();
        ask(`L_ESE, "7\n");
        cmd(`L_PSC, 8'h01);
        pwr();
        ask(`L_ESE, "0\n");
        $display("done power");
    endtask : t_psc

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_enables();
        t_errors();
        t_opc();
        t_misc();
        t_cls();
        t_psc();
        complete_run();
    end

    // whole run is well under a thousand cycles; this is ten thousand cycles
    initial
    begin
        #100us;
        fail_count++;
        complete_run();
    end
endmodule : common_command_status_unit_tb
